// ==== core/pis_top.sv ====
// summary interrupt status, mask and interrupt output of the port controller
// Operation
// - bit 7 ORs thermal, both undervoltage, digital warning, memory fault; resets to 1
// - bit 6 ORs the four start-timeout flags; resets to 0
// - bit 5 ORs four overload-timeout and four current-limit-timeout flags; resets to 0
// - bit 4 ORs the four classification-done flags; resets to 0
// - bit 3 ORs the four detection-done flags; resets to 0
// - bit 2 ORs the four disconnect flags; resets to 0
// - bit 1 ORs the four power-good-change flags; resets to 0
// - bit 0 ORs the four power-enable-change flags
// - reading a feeding event register clears its bit once flags are gone
// - writing 1 to reset register bit 7 clears the summary bits
// - interrupt only when a bit is active, mask bit set, global enable set
// - summary is read-only at command 00h, one active-high byte
// - summary bits track events regardless of mask settings
module pis_top (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    // event flags from the port engine
    input wire pis_pkg::pis_flags_s FLAGS_I,
    // per-bit pulse: host read of the clear-on-read event register feeding it
    input wire logic [7:0] EVT_READ_CLR_I,
    // global enable from the general mask register
    input wire logic GLOBAL_IRQ_ENABLE_I,
    // register command port
    input wire pis_pkg::pis_cmd_s CMD_I,
    output logic [7:0] RDATA_O,
    output logic RVALID_O,
    // interrupt
    output logic INT_N_O
);

    logic rst_meta_q;
    logic rst_n_q;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] summary_q;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic int_n_q;
    logic int_n_d;
    logic all_clr;
    logic mask_wr;
    logic irq_req;
    logic rd_summary;
    logic rd_mask;

    // reset release through two flops
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    function automatic logic any4(input logic [pis_pkg::CH_N-1:0] v);
        any4 = |v;
    endfunction

    function automatic logic cmd_is(input pis_pkg::pis_cmd_s c, input logic [7:0] code);
        cmd_is = (c.cmd == code);
    endfunction

    // summary sources
    assign set_vec[pis_pkg::BIT_SUPPLY] = FLAGS_I.thermal_shutdown_flag | FLAGS_I.digital_supply_undervolt
        | FLAGS_I.digital_supply_warning | FLAGS_I.power_supply_undervolt | FLAGS_I.program_memory_fault;
    assign set_vec[pis_pkg::BIT_START] = any4(FLAGS_I.start_timeout);
    assign set_vec[pis_pkg::BIT_OVERCUR] = any4(FLAGS_I.overload_timeout)
        | any4(FLAGS_I.current_limit_timeout);
    assign set_vec[pis_pkg::BIT_CLASS] = any4(FLAGS_I.class_done);
    assign set_vec[pis_pkg::BIT_DETECT] = any4(FLAGS_I.detect_done);
    assign set_vec[pis_pkg::BIT_DISC] = any4(FLAGS_I.disconnect);
    assign set_vec[pis_pkg::BIT_PGOOD] = any4(FLAGS_I.power_good_change);
    assign set_vec[pis_pkg::BIT_PEN] = any4(FLAGS_I.power_enable_change);

    // clear sources
    assign all_clr = CMD_I.wr && cmd_is(CMD_I, pis_pkg::CMD_RESET)
        && CMD_I.wdata[pis_pkg::RESET_CLR_BIT];
    assign clr_vec = EVT_READ_CLR_I | {8{all_clr}};

    // sticky bits, set wins, mask never involved
    for (genvar i = 0; i < pis_pkg::SUM_W; i++) begin : g_bit
        pis_sticky_bit #(
            .RST_VAL(pis_pkg::SUMMARY_RST[i])
        ) u_bit (
            .clk_i(CLK_SYS_I),
            .rst_n_i(rst_n_q),
            .set_i(set_vec[i]),
            .clr_i(clr_vec[i]),
            .q_o(summary_q[i])
        );
    end

    // mask register and read path
    assign mask_wr = CMD_I.wr && cmd_is(CMD_I, pis_pkg::CMD_MASK);
    assign mask_d = mask_wr ? CMD_I.wdata : mask_q;
    assign rd_summary = CMD_I.rd && cmd_is(CMD_I, pis_pkg::CMD_SUMMARY);
    assign rd_mask = CMD_I.rd && cmd_is(CMD_I, pis_pkg::CMD_MASK);

    // read data: unmapped codes return zero, no read keeps the last byte
    always_comb begin
        if (rd_summary) begin
            rdata_d = summary_q;
        end else if (rd_mask) begin
            rdata_d = mask_q;
        end else if (CMD_I.rd) begin
            rdata_d = 8'h00;
        end else begin
            rdata_d = rdata_q;
        end
    end

    // interrupt
    assign irq_req = (|(summary_q & mask_q)) && GLOBAL_IRQ_ENABLE_I;
    assign int_n_d = ~irq_req;

    always_ff @(posedge CLK_SYS_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= pis_pkg::MASK_RST;
            rdata_q <= pis_pkg::RDATA_RST;
            rvalid_q <= 1'b0;
            int_n_q <= 1'b1;
        end else begin
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            rvalid_q <= CMD_I.rd;
            int_n_q <= int_n_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign RVALID_O = rvalid_q;
    assign INT_N_O = int_n_q;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!rst_n_q);

    a_supply_bit_set:
        assert property (set_vec[7] |=> summary_q[7]) else $error("supply summary bit missed its set");
    a_start_bit_set:
        assert property (|FLAGS_I.start_timeout |=> summary_q[6]) else $error("start summary bit missed");
    a_overcur_bit_set:
        assert property (|{FLAGS_I.overload_timeout, FLAGS_I.current_limit_timeout} |=> summary_q[5])
        else $error("overcurrent summary bit missed");
    a_class_bit_set:
        assert property (|FLAGS_I.class_done |=> summary_q[4]) else $error("class summary bit missed");
    a_detect_bit_set:
        assert property (|FLAGS_I.detect_done |=> summary_q[3]) else $error("detect summary bit missed");
    a_disc_bit_set:
        assert property (|FLAGS_I.disconnect |=> summary_q[2]) else $error("disconnect summary bit missed");
    a_pgood_bit_set:
        assert property (|FLAGS_I.power_good_change |=> summary_q[1]) else $error("power good bit missed");
    a_pen_bit_set:
        assert property (|FLAGS_I.power_enable_change |=> summary_q[0]) else $error("power enable bit missed");
    a_read_bit_clear:
        assert property (1'b1 |=> ((summary_q & $past(EVT_READ_CLR_I & ~set_vec)) == 8'h00))
        else $error("summary bit survived its event register read");
    a_reset_reg_clear:
        assert property (all_clr && (set_vec == 8'h00) |=> summary_q == 8'h00)
        else $error("reset register write did not clear summary");
    a_irq_gating:
        assert property (!INT_N_O |-> $past(|(summary_q & mask_q)) && $past(GLOBAL_IRQ_ENABLE_I))
        else $error("interrupt asserted without an enabled cause");
    a_summary_read:
        assert property (CMD_I.rd && CMD_I.cmd == pis_pkg::CMD_SUMMARY |=> RVALID_O && RDATA_O == $past(summary_q))
        else $error("summary read returned wrong byte");
    a_mask_free_track:
        assert property (mask_q == 8'h00 && set_vec[0] |=> summary_q[0] ##0 INT_N_O)
        else $error("masked event not tracked or interrupt leaked");
    a_irq_release:
        assert property (!GLOBAL_IRQ_ENABLE_I |=> INT_N_O) else $error("interrupt held with global enable off");

    // interrupt, command port and mask register
    a_irq_follows_cause:
        assert property (irq_req |=> !INT_N_O)
        else $error("enabled unmasked cause did not raise the interrupt");
    a_irq_drop_unmasked:
        assert property (!(|(summary_q & mask_q)) |=> INT_N_O)
        else $error("interrupt held without an unmasked cause");
    a_rvalid_pulse:
        assert property (CMD_I.rd |=> RVALID_O)
        else $error("read gave no valid pulse");
    a_mask_read:
        assert property (rd_mask |=> RVALID_O && RDATA_O == $past(mask_q))
        else $error("mask read returned wrong byte");
    a_unmapped_read:
        assert property (CMD_I.rd && !rd_summary && !rd_mask |=> RVALID_O && RDATA_O == 8'h00)
        else $error("unmapped read returned a nonzero byte");
    a_rdata_hold:
        assert property (!CMD_I.rd |=> $stable(RDATA_O) && !RVALID_O)
        else $error("read data moved without a read");
    a_mask_write:
        assert property (mask_wr |=> mask_q == $past(CMD_I.wdata))
        else $error("mask write did not land");
    a_mask_hold:
        assert property (!mask_wr |=> $stable(mask_q))
        else $error("mask changed without a write");

    // summary tracking
    a_source_sets_bit:
        assert property (1'b1 |=> ((~summary_q & $past(set_vec)) == 8'h00))
        else $error("live source did not set its summary bit");
    a_bit_holds_set:
        assert property (1'b1 |=> ((~summary_q & $past(summary_q & ~clr_vec)) == 8'h00))
        else $error("summary bit dropped without a clear");
    a_bit_needs_source:
        assert property (1'b1 |=> ((summary_q & ~$past(summary_q | set_vec)) == 8'h00))
        else $error("summary bit rose without a source");

    c_irq_fires: cover property (INT_N_O ##1 !INT_N_O);
    c_read_clears: cover property (summary_q[1] ##1 EVT_READ_CLR_I[1] ##1 !summary_q[1]);
    c_reset_clear: cover property (summary_q[7] && all_clr ##1 summary_q == 8'h00);
    c_mask_write: cover property (mask_wr ##1 mask_q != pis_pkg::MASK_RST);
    c_masked_event: cover property (mask_q == 8'h00 && set_vec[pis_pkg::BIT_PEN]);

endmodule

// ==== core/pis_pkg.sv ====
// constants and carrier types for the port interrupt summary block
package pis_pkg;

    // summary register layout
    localparam int SUM_W = 8;
    localparam int BIT_SUPPLY = 7;
    localparam int BIT_START = 6;
    localparam int BIT_OVERCUR = 5;
    localparam int BIT_CLASS = 4;
    localparam int BIT_DETECT = 3;
    localparam int BIT_DISC = 2;
    localparam int BIT_PGOOD = 1;
    localparam int BIT_PEN = 0;
    localparam int CH_N = 4;

    // command codes
    localparam logic [7:0] CMD_SUMMARY = 8'h00;
    localparam logic [7:0] CMD_MASK = 8'h01;
    localparam logic [7:0] CMD_RESET = 8'h1f;
    localparam int RESET_CLR_BIT = 7;

    // reset values
    localparam logic [7:0] SUMMARY_RST = 8'h80;
    localparam logic [7:0] MASK_RST = 8'h80;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // per-channel and global event flags from the port engine
    typedef struct packed {
        logic thermal_shutdown_flag;
        logic digital_supply_undervolt;
        logic digital_supply_warning;
        logic power_supply_undervolt;
        logic program_memory_fault;
        logic [CH_N-1:0] start_timeout;
        logic [CH_N-1:0] overload_timeout;
        logic [CH_N-1:0] current_limit_timeout;
        logic [CH_N-1:0] class_done;
        logic [CH_N-1:0] detect_done;
        logic [CH_N-1:0] disconnect;
        logic [CH_N-1:0] power_good_change;
        logic [CH_N-1:0] power_enable_change;
    } pis_flags_s;

    // register command port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } pis_cmd_s;

endpackage

// ==== core/pis_sticky_bit.sv ====
// one sticky summary bit where a set beats a clear
module pis_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic set_i,
    input wire logic clr_i,
    // state
    output logic q_o
);

    logic q_q;
    logic q_d;

    assign q_d = set_i | (q_q & ~clr_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_q <= RST_VAL;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_o = q_q;

endmodule

// ==== testbench/pis_host_model.sv ====
// host processor model issuing register commands and event register reads
module pis_host_model (
    // clock
    input wire logic clk_i,
    // read answer
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    // requests
    output pis_pkg::pis_cmd_s cmd_o,
    output logic [7:0] clr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_o = '0;
        clr_o = 8'h00;
    end
    // one command for one taking edge, read data caught with its valid
    task automatic access(input logic rd, input logic wr, input logic [7:0] c, input logic [7:0] w,
        output logic [7:0] d);
        @(negedge clk_i);
        cmd_o = {rd, wr, c, w};
        @(negedge clk_i);
        cmd_o = '0;
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
    // clear-on-read of the event registers behind the given bits
    task automatic ack(input logic [7:0] m);
        @(negedge clk_i);
        clr_o = m;
        @(negedge clk_i);
        clr_o = 8'h00;
    endtask
endmodule

// ==== testbench/poe_port_interrupt_summary_tb_top.sv ====
// self-checking bench of the summary interrupt block
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module poe_port_interrupt_summary_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n, en, rvalid, int_n;
    logic [7:0] clr, rdata, d, m, e;
    logic [31:0] seed = 32'd51;
    logic [31:0] r;
    pis_pkg::pis_flags_s flags, f;
    pis_pkg::pis_cmd_s cmd;
    int num_errors = 0;
    int samples_checked = 0;
    always #12.5 clk = ~clk;
    pis_top u_dut (.CLK_SYS_I(clk), .RSTN_I(rst_n), .FLAGS_I(flags), .EVT_READ_CLR_I(clr),
        .GLOBAL_IRQ_ENABLE_I(en), .CMD_I(cmd), .RDATA_O(rdata), .RVALID_O(rvalid), .INT_N_O(int_n));
    pis_host_model u_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_o(cmd), .clr_o(clr));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_sum(pis_pkg::pis_flags_s x);
        return {x.thermal_shutdown_flag | x.digital_supply_undervolt | x.digital_supply_warning |
            x.power_supply_undervolt | x.program_memory_fault, |x.start_timeout,
            |{x.overload_timeout, x.current_limit_timeout}, |x.class_done, |x.detect_done,
            |x.disconnect, |x.power_good_change, |x.power_enable_change};
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(25ns * 20000);
        num_errors++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        flags = '0;
        en = 1'b1;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(int_n, 1'b0)
        u_host.access(1'b1, 1'b0, pis_pkg::CMD_SUMMARY, 8'h00, d);
        `CHK(d, 8'h80)
        u_host.access(1'b1, 1'b0, pis_pkg::CMD_MASK, 8'h00, d);
        `CHK(d, 8'h80)
        for (int i = 0; i < 40; i++) begin
            r = xs();
            m = r[15:8];
            u_host.access(1'b0, 1'b1, pis_pkg::CMD_RESET, 8'h80, d);
            u_host.access(1'b0, 1'b1, pis_pkg::CMD_MASK, m, d);
            f = i[0] ? 37'h1 << (xs() % 37) : 37'({xs(), xs()} & {xs(), xs()});
            @(negedge clk);
            en = r[0];
            flags = f;
            @(negedge clk);
            flags = '0;
            e = exp_sum(f);
            u_host.access(1'b1, 1'b0, pis_pkg::CMD_SUMMARY, 8'h00, d);
            `CHK(d, e)
            `CHK(int_n, ~(|(e & m) & en))
            if (r[1]) u_host.ack(e);
            else u_host.access(1'b0, 1'b1, pis_pkg::CMD_RESET, 8'h80, d);
            u_host.access(1'b0, 1'b1, pis_pkg::CMD_SUMMARY, 8'hff, d);
            u_host.access(1'b1, 1'b0, pis_pkg::CMD_SUMMARY, 8'h00, d);
            `CHK(d, 8'h00)
            `CHK(int_n, 1'b1)
        end
        @(negedge clk);
        flags.detect_done = 4'h4;
        u_host.ack(8'h08);
        flags = '0;
        u_host.access(1'b1, 1'b0, pis_pkg::CMD_SUMMARY, 8'h00, d);
        `CHK(d, 8'h08)
        u_host.access(1'b1, 1'b1, pis_pkg::CMD_MASK, 8'h00, d);
        `CHK(d, m)
        en = 1'b1;
        flags.power_enable_change = 4'h2;
        @(negedge clk);
        flags = '0;
        repeat (2) @(negedge clk);
        `CHK(int_n, 1'b1)
        u_host.access(1'b1, 1'b0, pis_pkg::CMD_SUMMARY, 8'h00, d);
        `CHK(d, 8'h09)
        u_host.access(1'b1, 1'b0, pis_pkg::CMD_RESET, 8'h00, d);
        `CHK(d, 8'h00)
        wrap_up();
    end
endmodule
